/* File: rtl/tocp_timer_pwm.sv */
// Purpose: Two-channel 16-bit timer output compare and PWM with APB registers
// Assumes: Registers one word each, zero wait state APB, all inputs synchronous
// Notes:   Pins are output level plus enable; enable low leaves pin to the port
// What this block does
// - Unbuffered compare uses the value register as currently held.
// - Value written below the counter gives no compare that period.
// - Compare event and request at counter match with value.
// - Overflow event and request at each period end.
// - Pair link bit joins channels, output on channel 0 pin.
// - Channel 0 value rules first; channel 1 after written, at overflow.
// - Each later overflow selects the most recently written value register.
// - Channel 0 control governs linked function; channel 1 control ignored.
// - Linked mode releases channel 1 pin to general purpose use.
// - Overflow toggle flips pin when counter reaches modulo.
// - Pulse width spans overflow to compare match.
// - Modulo 255 with prescaler 000 gives 256 clock period.
// - Value 128 in 256-step period gives 50 percent duty.
// - Halt bit stops counting; reset sets it.
// - Counter clear bit zeroes counter and prescaler, reads zero.
// - Overflow flag sets when counter reaches modulo.
module tocp_timer_pwm
(
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             channel0Pin,
    output logic             channel0PinOe,
    output logic             channel1Pin,
    output logic             channel1PinOe,
    output logic             overflowIrq,
    output logic             compareIrq0,
    output logic             compareIrq1
);
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] modulo;
        logic [2:0]  ps;
        logic        halt;
        logic        ovIe;
        logic        ovFlag;
        logic        ovArmed;
        logic [1:0][7:0]  cs;
        logic [1:0][15:0] val;
        logic [1:0]  armed;
        logic [1:0]  pin;
        logic        active;
        logic        pend1;
        logic        lastWr;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        ovIrq;
        logic [1:0]  cmpIrq;
        logic [1:0]  oe;
    } tocp_state_t;

    tocp_state_t s_q;
    tocp_state_t s_d;
    logic        tick;
    logic        clrReq;
    logic        access;
    logic        wr;
    logic        atMod;
    logic [15:0] nextCnt;
    logic        linked;
    logic [1:0]  match;
    logic [15:0] cmpVal [2];

    function automatic logic outputMode(input logic [7:0] cs);
        outputMode = cs[tocp_pkg::CS_MS_LSB +: 2] != 2'b00;
    endfunction

    function automatic logic applyEls(input logic [1:0] els, input logic pin);
        unique case (els)
            tocp_pkg::ELS_TOGGLE: applyEls = ~pin;
            tocp_pkg::ELS_CLEAR:  applyEls = 1'b0;
            tocp_pkg::ELS_SET:    applyEls = 1'b1;
            default:              applyEls = pin;
        endcase
    endfunction

    assign access = psel && penable;
    assign wr     = access && pwrite;
    assign clrReq = wr && paddr == tocp_pkg::OFS_CTRL && pwdata[tocp_pkg::CTRL_CLEAR_BIT];
    assign atMod  = tick && s_q.count == s_q.modulo;
    assign nextCnt = atMod ? tocp_pkg::COUNT_RESET : 16'(s_q.count + 16'h0001);
    assign linked = s_q.cs[0][tocp_pkg::CS_MS_LSB + 1];

    tocp_prescaler u_ps
    (
        .clock (clock),
        .rstn  (rstn),
        .clear (clrReq),
        .run   (~s_q.halt),
        .sel   (s_q.ps),
        .tick  (tick)
    );

    // Linked pair compares against the active buffer only
    always_comb
    begin
        cmpVal[0] = (linked && s_q.active) ? s_q.val[1] : s_q.val[0];
        cmpVal[1] = s_q.val[1];
    end

    always_comb
    begin
        s_d = s_q;
        s_d.ready  = 1'b0;
        s_d.err    = 1'b0;
        s_d.rdata  = 32'h0000_0000;
        match      = 2'b00;

        // Counter, halted by reset until software clears halt
        if (tick && !s_q.halt)
        begin
            s_d.count = nextCnt;
        end

        // Compares use the live value; no holding stage, so a value written below
        // the counter simply misses this period
        for (int i = 0; i < 2; i++)
        begin
            // Match as the counter steps onto the value, so the width is exactly the value
            match[i] = tick && !s_q.halt && nextCnt == cmpVal[i]
                       && outputMode(s_q.cs[i]) && !(i == 1 && linked);
            if (match[i])
            begin
                s_d.cs[i][tocp_pkg::CS_FLAG_BIT] = 1'b1;
                if (!(s_q.cs[i][tocp_pkg::CS_TOV_BIT] && atMod))
                begin
                    s_d.pin[i] = applyEls(s_q.cs[i][tocp_pkg::CS_ELS_LSB +: 2], s_q.pin[i]);
                end
            end
            // Overflow toggle wins over a simultaneous compare
            if (atMod && !s_q.halt && outputMode(s_q.cs[i]) && s_q.cs[i][tocp_pkg::CS_TOV_BIT]
                && !(i == 1 && linked))
            begin
                s_d.pin[i] = ~s_q.pin[i];
                if (s_q.cs[i][tocp_pkg::CS_MAX_BIT])
                begin
                    s_d.pin[i] = s_q.cs[i][tocp_pkg::CS_ELS_LSB] ? 1'b0 : 1'b1;
                end
            end
            s_d.oe[i] = s_q.cs[i][tocp_pkg::CS_ELS_LSB +: 2] != tocp_pkg::ELS_NONE
                        && !(i == 1 && linked);
        end

        if (atMod && !s_q.halt)
        begin
            s_d.ovFlag = 1'b1;
            if (linked && s_q.pend1)
            begin
                s_d.active = s_q.lastWr;
            end
        end

        // APB, zero wait state
        s_d.ready = psel && !penable;
        if (psel && !penable && !pwrite)
        begin
            unique case (paddr)
                tocp_pkg::OFS_CTRL:   s_d.rdata = {24'h00_0000, s_q.ovFlag, s_q.ovIe, s_q.halt,
                                                   1'b0, 1'b0, s_q.ps};
                tocp_pkg::OFS_COUNT:  s_d.rdata = {16'h0000, s_q.count};
                tocp_pkg::OFS_MOD:    s_d.rdata = {16'h0000, s_q.modulo};
                tocp_pkg::OFS_CH0CS:  s_d.rdata = {24'h00_0000, s_q.cs[0]};
                tocp_pkg::OFS_CH0VAL: s_d.rdata = {16'h0000, s_q.val[0]};
                tocp_pkg::OFS_CH1CS:  s_d.rdata = {24'h00_0000, s_q.cs[1]};
                tocp_pkg::OFS_CH1VAL: s_d.rdata = {16'h0000, s_q.val[1]};
                default:              s_d.err   = 1'b1;
            endcase
            s_d.ovArmed = paddr == tocp_pkg::OFS_CTRL && s_q.ovFlag;
            for (int i = 0; i < 2; i++)
            begin
                if (paddr == (i == 0 ? tocp_pkg::OFS_CH0CS : tocp_pkg::OFS_CH1CS))
                begin
                    s_d.armed[i] = s_q.cs[i][tocp_pkg::CS_FLAG_BIT];
                end
            end
        end
        if (psel && !penable && pwrite)
        begin
            s_d.err = !(paddr inside {tocp_pkg::OFS_CTRL, tocp_pkg::OFS_COUNT, tocp_pkg::OFS_MOD,
                        tocp_pkg::OFS_CH0CS, tocp_pkg::OFS_CH0VAL, tocp_pkg::OFS_CH1CS,
                        tocp_pkg::OFS_CH1VAL});
        end
        if (wr)
        begin
            unique case (paddr)
                tocp_pkg::OFS_CTRL:
                begin
                    s_d.ps   = pwdata[tocp_pkg::CTRL_PS_LSB +: 3];
                    s_d.halt = pwdata[tocp_pkg::CTRL_HALT_BIT];
                    s_d.ovIe = pwdata[tocp_pkg::CTRL_OVIE_BIT];
                    // Two-step clear; a new overflow in this cycle keeps the flag
                    if (!pwdata[tocp_pkg::CTRL_OVF_BIT] && s_q.ovArmed && !(atMod && !s_q.halt))
                    begin
                        s_d.ovFlag = 1'b0;
                    end
                    s_d.ovArmed = 1'b0;
                    if (pwdata[tocp_pkg::CTRL_CLEAR_BIT])
                    begin
                        s_d.count = tocp_pkg::COUNT_RESET;
                    end
                end
                tocp_pkg::OFS_MOD:    s_d.modulo = pwdata[15:0];
                tocp_pkg::OFS_CH0VAL:
                begin
                    s_d.val[0] = pwdata[15:0];
                    s_d.lastWr = 1'b0;
                end
                tocp_pkg::OFS_CH1VAL:
                begin
                    s_d.val[1] = pwdata[15:0];
                    s_d.lastWr = 1'b1;
                    s_d.pend1  = 1'b1;
                end
                tocp_pkg::OFS_CH0CS, tocp_pkg::OFS_CH1CS:
                begin
                    for (int i = 0; i < 2; i++)
                    begin
                        if (paddr == (i == 0 ? tocp_pkg::OFS_CH0CS : tocp_pkg::OFS_CH1CS))
                        begin
                            s_d.cs[i][6:0] = pwdata[6:0];
                            if (!pwdata[tocp_pkg::CS_FLAG_BIT] && s_q.armed[i] && !match[i])
                            begin
                                s_d.cs[i][tocp_pkg::CS_FLAG_BIT] = 1'b0;
                            end
                            s_d.armed[i] = 1'b0;
                            // Output preset level taken while not in output mode or while no edge is selected
                            if (pwdata[tocp_pkg::CS_MS_LSB +: 2] == 2'b00
                                || pwdata[tocp_pkg::CS_ELS_LSB +: 2] == tocp_pkg::ELS_NONE)
                            begin
                                s_d.pin[i] = ~pwdata[tocp_pkg::CS_MS_LSB];
                            end
                        end
                    end
                    if (paddr == tocp_pkg::OFS_CH0CS && !pwdata[tocp_pkg::CS_MS_LSB + 1])
                    begin
                        s_d.active = 1'b0;
                        s_d.pend1  = 1'b0;
                    end
                end
                default:
                begin
                end
            endcase
        end

        s_d.ovIrq  = s_d.ovFlag && s_d.ovIe;
        for (int i = 0; i < 2; i++)
        begin
            s_d.cmpIrq[i] = s_d.cs[i][tocp_pkg::CS_FLAG_BIT] && s_d.cs[i][tocp_pkg::CS_IE_BIT]
                            && !(i == 1 && s_d.cs[0][tocp_pkg::CS_MS_LSB + 1]);
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q        <= '0;
            s_q.modulo <= tocp_pkg::MOD_RESET;
            s_q.halt   <= 1'b1;
            s_q.pin    <= 2'b11;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata        = s_q.rdata;
    assign pready        = s_q.ready;
    assign pslverr       = s_q.err;
    assign channel0Pin   = s_q.pin[0];
    assign channel0PinOe = s_q.oe[0];
    assign channel1Pin   = s_q.pin[1];
    assign channel1PinOe = s_q.oe[1];
    assign overflowIrq   = s_q.ovIrq;
    assign compareIrq0   = s_q.cmpIrq[0];
    assign compareIrq1   = s_q.cmpIrq[1];

    halt_reset_a: assert property (@(posedge clock) disable iff (!rstn)
        s_q.halt |=> $stable(s_q.count) || $past(clrReq)) else $error("count moved while halted");
    clear_zero_a: assert property (@(posedge clock) disable iff (!rstn)
        clrReq |=> s_q.count == 16'h0000) else $error("clear did not zero counter");
    wrap_zero_a: assert property (@(posedge clock) disable iff (!rstn)
        atMod && !s_q.halt && !clrReq |=> s_q.count == 16'h0000 && s_q.ovFlag)
        else $error("no wrap or flag at modulo");
    toggle_ovf_a: assert property (@(posedge clock) disable iff (!rstn)
        atMod && !s_q.halt && s_q.cs[0][1] && s_q.cs[0][5:4] != 2'b00 && !s_q.cs[0][0] && !wr
        |=> s_q.pin[0] != $past(s_q.pin[0])) else $error("no toggle on overflow");
    cmp_flag_a: assert property (@(posedge clock) disable iff (!rstn)
        match[0] |=> s_q.cs[0][7]) else $error("compare flag not set");
    link_release_a: assert property (@(posedge clock) disable iff (!rstn)
        linked |=> !s_q.oe[1] || !$past(linked)) else $error("pin1 held while linked");
    buf_swap_a: assert property (@(posedge clock) disable iff (!rstn)
        linked && s_q.pend1 && atMod && !s_q.halt && !wr |=> s_q.active == $past(s_q.lastWr))
        else $error("buffer not switched at overflow");
    clear_pin_a: assert property (@(posedge clock) disable iff (!rstn)
        match[0] && s_q.cs[0][3:2] == 2'b10 && !atMod && !wr |=> !s_q.pin[0])
        else $error("clear on compare failed");
endmodule

/* File: rtl/tocp_pkg.sv */
// Purpose: Shared constants for the timer output compare and PWM block
// Assumes: 32-bit APB, one word per register
// Notes:   Offsets are byte addresses
package tocp_pkg;
    localparam logic [11:0] OFS_CTRL   = 12'h0000;
    localparam logic [11:0] OFS_COUNT  = 12'h0004;
    localparam logic [11:0] OFS_MOD    = 12'h0008;
    localparam logic [11:0] OFS_CH0CS  = 12'h000C;
    localparam logic [11:0] OFS_CH0VAL = 12'h0010;
    localparam logic [11:0] OFS_CH1CS  = 12'h0014;
    localparam logic [11:0] OFS_CH1VAL = 12'h0018;
    // Timer control/status fields
    localparam int CTRL_PS_LSB    = 0;
    localparam int CTRL_CLEAR_BIT = 4;
    localparam int CTRL_HALT_BIT  = 5;
    localparam int CTRL_OVIE_BIT  = 6;
    localparam int CTRL_OVF_BIT   = 7;
    // Channel control/status fields
    localparam int CS_MAX_BIT  = 0;
    localparam int CS_TOV_BIT  = 1;
    localparam int CS_ELS_LSB  = 2;
    localparam int CS_MS_LSB   = 4;
    localparam int CS_IE_BIT   = 6;
    localparam int CS_FLAG_BIT = 7;
    localparam logic [15:0] MOD_RESET   = 16'hFFFF;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [2:0]  PS_EXTERNAL = 3'h7;
    localparam logic [1:0]  ELS_TOGGLE  = 2'h1;
    localparam logic [1:0]  ELS_CLEAR   = 2'h2;
    localparam logic [1:0]  ELS_SET     = 2'h3;
    localparam logic [1:0]  ELS_NONE    = 2'h0;
endpackage

/* File: rtl/tocp_prescaler.sv */
// Purpose: Divides the bus clock into the timer tick enable
// Assumes: Select 7 is an external clock that is not present here
// Notes:   Clear restarts the divider so the first tick is a full period
module tocp_prescaler
(
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       clear,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output logic            tick
);
    typedef struct packed {
        logic [5:0] div;
        logic       tick;
    } tocp_ps_t;

    tocp_ps_t s_q;
    tocp_ps_t s_d;
    logic [5:0] mask;

    always_comb
    begin
        mask = (sel == 3'd0) ? 6'h00 : 6'(7'h7F >> (3'd7 - sel));
        s_d = s_q;
        s_d.tick = 1'b0;
        if (clear)
        begin
            s_d.div = 6'h00;
        end
        else if (run && sel != tocp_pkg::PS_EXTERNAL)
        begin
            if ((s_q.div & mask) == mask)
            begin
                s_d.div  = 6'h00;
                s_d.tick = 1'b1;
            end
            else
            begin
                s_d.div = 6'(s_q.div + 6'h01);
            end
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule

/* File: test/tocp_pin_monitor.sv */
// Purpose: Load on a timer channel pin that measures pulse high time and period
// Assumes: Pin is sampled on the bus clock; only edges seen while driven count
// Notes:   Widths are zero until the first driven edge of the kind that loads them
module tocp_pin_monitor
(
    input  wire logic        clock,
    input  wire logic        pin,
    input  wire logic        pinOe,
    output logic      [15:0] highWidth,
    output logic      [15:0] periodLen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic        pinQ = 1'b1;
    logic [15:0] sinceRise = 16'h0000;
    initial
    begin
        highWidth = 16'h0000;
        periodLen = 16'h0000;
    end
    always @(posedge clock)
    begin
        pinQ <= pin;
        sinceRise <= sinceRise + 16'h0001;
        if (pinOe && pin && !pinQ)
        begin
            periodLen <= sinceRise;
            sinceRise <= 16'h0001;
        end
        if (pinOe && !pin && pinQ)
        begin
            highWidth <= sinceRise;
        end
    end
endmodule

/* File: test/tb.sv */
// Purpose: Self-checking bench for the timer output compare and PWM block
// Assumes: Prescale 0, so widths and periods are counted in bus clocks
// Notes:   Each PWM check waits three periods so stale edges have flushed
`define CHK(nm, ex, got) begin checksDone++; if ((got) !== (ex)) begin errCount++; \
    $display("BAD %s expected %h seen %h", nm, ex, got); end end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ch0Pin;
    logic        ch0Oe;
    logic        ch1Pin;
    logic        ch1Oe;
    logic        ovIrq;
    logic        cmpIrq0;
    logic        cmpIrq1;
    logic [15:0] highW;
    logic [15:0] perLen;
    logic [31:0] rdat;
    logic        rerr;
    logic [15:0] md;
    logic [15:0] vl;
    logic [1:0]  els;
    logic [31:0] cnt;
    int          errCount = 0;
    int          checksDone = 0;
    always #50 clock = ~clock;
    tocp_timer_pwm u_dut
    (
        .clock         (clock),
        .rstn          (rstn),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .channel0Pin   (ch0Pin),
        .channel0PinOe (ch0Oe),
        .channel1Pin   (ch1Pin),
        .channel1PinOe (ch1Oe),
        .overflowIrq   (ovIrq),
        .compareIrq0   (cmpIrq0),
        .compareIrq1   (cmpIrq1)
    );
    tocp_pin_monitor u_load
    (
        .clock     (clock),
        .pin       (ch0Pin),
        .pinOe     (ch0Oe),
        .highWidth (highW),
        .periodLen (perLen)
    );
    task automatic stopTest();
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            errCount++;
            stopTest();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
        apb(1'b1, ad, wd);
    endtask
    // Only clear or set on compare is ever selected for PWM
    function automatic logic [31:0] csWord(input logic [1:0] e, input logic lk, input logic ie);
        csWord = {24'h00_0000, 1'b0, ie, lk, !lk, e, 1'b1, 1'b0};
    endfunction
    function automatic logic [15:0] expHigh(input logic [15:0] m, input logic [15:0] v,
                                            input logic [1:0] e);
        // Set-on-compare makes the low phase the pulse, so the high phase is the rest
        expHigh = (e == tocp_pkg::ELS_CLEAR) ? v : m + 16'h0001 - v;
    endfunction
    task automatic pwmSetup(input logic [15:0] m, input logic [15:0] v, input logic [1:0] e,
                            input logic lk);
        wr(tocp_pkg::OFS_CTRL, 32'h0000_0030);
        wr(tocp_pkg::OFS_MOD, {16'h0000, m});
        wr(tocp_pkg::OFS_CH0VAL, {16'h0000, v});
        wr(tocp_pkg::OFS_CH0CS, csWord(e, lk, 1'b0));
        wr(tocp_pkg::OFS_CTRL, 32'h0000_0000);
    endtask
    task automatic checkPwm(input logic [15:0] m, input logic [15:0] v, input logic [1:0] e);
        repeat (3 * (m + 1)) @(posedge clock);
        `CHK("period", m + 16'h0001, perLen)
        `CHK("high width", expHigh(m, v, e), highW)
    endtask
    task automatic waitIrq(input int which);
        int n;
        logic seen;
        seen = 1'b0;
        for (n = 0; n < 600 && !seen; n++)
        begin
            @(posedge clock);
            seen = (which == 0) ? ovIrq : cmpIrq0;
        end
        `CHK("irq raised", 1'b1, seen)
    endtask
    initial
    begin
        void'($urandom(74));
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        apb(1'b0, tocp_pkg::OFS_CTRL, 32'h0000_0000);
        `CHK("halt at reset", 1'b1, rdat[tocp_pkg::CTRL_HALT_BIT])
        `CHK("ch1 pin reset", 1'b1, ch1Pin)
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        `CHK("unmapped error", 1'b1, rerr)
        `CHK("unmapped data", 32'h0000_0000, rdat)
        wr(tocp_pkg::OFS_CTRL, 32'h0000_0000);
        repeat (40) @(posedge clock);
        wr(tocp_pkg::OFS_CTRL, 32'h0000_0030);
        apb(1'b0, tocp_pkg::OFS_COUNT, 32'h0000_0000);
        `CHK("count cleared", 32'h0000_0000, rdat)
        apb(1'b0, tocp_pkg::OFS_CTRL, 32'h0000_0000);
        `CHK("clear reads 0", 1'b0, rdat[tocp_pkg::CTRL_CLEAR_BIT])
        repeat (20) @(posedge clock);
        apb(1'b0, tocp_pkg::OFS_COUNT, 32'h0000_0000);
        `CHK("count halted", 32'h0000_0000, rdat)
        $display("test registers done");
        for (int k = 0; k < 2; k++)
        begin
            els = k ? tocp_pkg::ELS_SET : tocp_pkg::ELS_CLEAR;
            pwmSetup(16'h00FF, 16'h0080, els, 1'b0);
            checkPwm(16'h00FF, 16'h0080, els);
        end
        for (int k = 0; k < 6; k++)
        begin
            els = ($urandom % 2) ? tocp_pkg::ELS_SET : tocp_pkg::ELS_CLEAR;
            md = 16'h0020 + 16'($urandom % 64);
            vl = 16'h0001 + 16'($urandom % (md - 1));
            pwmSetup(md, vl, els, 1'b0);
            checkPwm(md, vl, els);
            vl = 16'h0001 + 16'($urandom % (md - 1));
            wr(tocp_pkg::OFS_CH0VAL, {16'h0000, vl});
            checkPwm(md, vl, els);
        end
        $display("test pwm done");
        pwmSetup(16'h00FF, 16'h0080, tocp_pkg::ELS_CLEAR, 1'b0);
        wr(tocp_pkg::OFS_CTRL, 32'h0000_0040);
        waitIrq(0);
        apb(1'b0, tocp_pkg::OFS_CTRL, 32'h0000_0000);
        `CHK("overflow flag", 1'b1, rdat[tocp_pkg::CTRL_OVF_BIT])
        wr(tocp_pkg::OFS_CTRL, 32'h0000_0040);
        repeat (3) @(posedge clock);
        `CHK("overflow irq cleared", 1'b0, ovIrq)
        wr(tocp_pkg::OFS_CTRL, 32'h0000_0020);
        apb(1'b0, tocp_pkg::OFS_CH0CS, 32'h0000_0000);
        wr(tocp_pkg::OFS_CH0CS, csWord(tocp_pkg::ELS_CLEAR, 1'b0, 1'b1));
        repeat (2) @(posedge clock);
        `CHK("compare irq cleared", 1'b0, cmpIrq0)
        wr(tocp_pkg::OFS_CTRL, 32'h0000_0040);
        waitIrq(1);
        $display("test events done");
        pwmSetup(16'h00FF, 16'h0028, tocp_pkg::ELS_CLEAR, 1'b1);
        wr(tocp_pkg::OFS_CH1CS, csWord(tocp_pkg::ELS_SET, 1'b0, 1'b1));
        checkPwm(16'h00FF, 16'h0028, tocp_pkg::ELS_CLEAR);
        `CHK("ch1 pin released", 1'b0, ch1Oe)
        wr(tocp_pkg::OFS_CH1VAL, 32'h0000_0064);
        checkPwm(16'h00FF, 16'h0064, tocp_pkg::ELS_CLEAR);
        `CHK("ch1 irq held", 1'b0, cmpIrq1)
        wr(tocp_pkg::OFS_CH0VAL, 32'h0000_003C);
        checkPwm(16'h00FF, 16'h003C, tocp_pkg::ELS_CLEAR);
        $display("test linked done");
        stopTest();
    end
endmodule
